// ---- rtl/amm_pkg.sv ----
// shared constants, carrier types and gain decoding for the audio mixing matrix
package amm_pkg;

	// channel counts and widths
	localparam int N_HW_IN  = 14;
	localparam int N_PLAY   = 16;
	localparam int N_SRC    = N_HW_IN + N_PLAY;
	localparam int N_OUT    = 16;
	localparam int N_PAIR   = N_SRC / 2;
	localparam int SAMP_W   = 24;
	localparam int GAIN_W   = 8;
	localparam int LIN_W    = 16;
	localparam int SRC_W    = 5;
	localparam int DST_W    = 4;
	localparam int PAN_W    = 5;
	localparam int WORD_W   = GAIN_W * N_OUT;
	localparam int LIN_FRAC = 15;
	localparam int ACC_W    = SAMP_W + LIN_W + SRC_W;
	localparam int ABS_W    = SAMP_W - 1;
	localparam int MS_W     = 32;
	localparam int SQ_LSB   = 7;

	// gain code: 0.5 dB steps below unity, zero means minus infinity
	localparam logic [GAIN_W-1:0] GAIN_MUTE  = 8'h00;
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 8'hFF;
	localparam logic [GAIN_W-1:0] GAIN_ATT_X = 8'hFF;
	localparam logic [GAIN_W-1:0] STEPS_6DB  = 8'h0C;

	// pan position 0 full left, 12 centre, 24 full right
	localparam logic [PAN_W-1:0] PAN_CENTRE = 5'h0C;
	localparam logic [PAN_W-1:0] PAN_FULL   = 5'h18;

	// output saturation limits
	localparam logic [SAMP_W-1:0] OUT_MAX = 24'h7FFFFF;
	localparam logic [SAMP_W-1:0] OUT_MIN = 24'h800000;
	localparam logic [ABS_W-1:0]  ABS_FS  = 23'h7FFFFF;

	// timing
	localparam int CLK_HZ         = 20_000_000;
	localparam int REFRESH_HZ     = 2;
	localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_HZ;
	localparam int REFRESH_CNT_W  = 24;
	localparam int RMS_SHIFT      = 12;

	// source index bounds: last source and reset value
	localparam logic [SRC_W-1:0] LAST_SRC = 5'h1D;
	localparam logic [SRC_W-1:0] SRC_ZERO = 5'h00;

	typedef enum logic [2:0] {
		AMM_S_CLEAR  = 3'h0,
		AMM_S_IDLE   = 3'h1,
		AMM_S_SWEEP  = 3'h3,
		AMM_S_DONE   = 3'h2,
		AMM_S_CMD_RD = 3'h6,
		AMM_S_CMD_WR = 3'h7
	} amm_state_t;

	typedef struct packed {
		logic [SRC_W-1:0]  src;
		logic [DST_W-1:0]  dst;
		logic [GAIN_W-1:0] gain;
	} amm_cmd_t;

	typedef struct packed {
		logic             over;
		logic [ABS_W-1:0] peak;
		logic [MS_W-1:0]  ms;
		logic [MS_W-1:0]  readout;
	} amm_meter_t;

	// log gain code to linear Q1.15 factor
	function automatic logic [LIN_W-1:0] amm_gain_to_lin(input logic [GAIN_W-1:0] code);
		logic [GAIN_W-1:0] a;
		logic [4:0]        q;
		logic [3:0]        r;
		logic [LIN_W-1:0]  m;
		a = GAIN_UNITY - code;
		q = 5'(a / STEPS_6DB);
		r = 4'(a % STEPS_6DB);
		case (r)
			4'h0: m = 16'h7FFF;
			4'h1: m = 16'h78D6;
			4'h2: m = 16'h7215;
			4'h3: m = 16'h6BB3;
			4'h4: m = 16'h65AD;
			4'h5: m = 16'h5FFD;
			4'h6: m = 16'h5A9E;
			4'h7: m = 16'h558C;
			4'h8: m = 16'h50C3;
			4'h9: m = 16'h4C3F;
			4'hA: m = 16'h47FB;
			4'hB: m = 16'h43F4;
			default: m = 16'h7FFF;
		endcase
		amm_gain_to_lin = (code == GAIN_MUTE) ? 16'h0000 : (m >> q);
	endfunction

	// attenuation in gain steps for one side of a pan position
	function automatic logic [GAIN_W-1:0] amm_pan_att(input logic [PAN_W-1:0] pan, input logic right);
		logic [PAN_W-1:0] p;
		logic [PAN_W-1:0] pp;
		p  = (pan > PAN_FULL) ? PAN_FULL : pan;
		pp = right ? (PAN_FULL - p) : p;
		amm_pan_att = (pp >= PAN_FULL) ? GAIN_ATT_X : {4'h0, pp[4:1]};
	endfunction

endpackage

// ---- rtl/amm_gain_mem.sv ----
// send gain store: one word per source, one byte lane per output
`timescale 1ns/1ps
module amm_gain_mem (
	input  wire logic                        mclk,
	input  wire logic                        rstn,
	input  wire logic                        rd_en,
	input  wire logic [amm_pkg::SRC_W-1:0]   rd_addr,
	output logic      [amm_pkg::WORD_W-1:0]  rd_data_r,
	input  wire logic                        wr_en,
	input  wire logic [amm_pkg::SRC_W-1:0]   wr_addr,
	input  wire logic [amm_pkg::N_OUT-1:0]   wr_lane,
	input  wire logic [amm_pkg::WORD_W-1:0]  wr_data
);

	logic [amm_pkg::WORD_W-1:0] mem [amm_pkg::N_SRC];

	// lane writes leave the other sends of the word untouched
	always_ff @(posedge mclk) begin
		if (wr_en && (wr_addr <= amm_pkg::LAST_SRC)) begin
			for (int l = 0; l < amm_pkg::N_OUT; l++) begin
				if (wr_lane[l]) begin
					mem[wr_addr][l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W] <= wr_data[l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W];
				end
			end
		end
	end

	// registered read, out of range reads as all muted
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_data_r <= '0;
		end else if (rd_en) begin
			rd_data_r <= (rd_addr <= amm_pkg::LAST_SRC) ? mem[rd_addr] : '0;
		end
	end

endmodule

// ---- rtl/amm_meter.sv ----
// peak and rms level meter for one channel
`timescale 1ns/1ps
module amm_meter (
	input  wire logic                        mclk,
	input  wire logic                        rstn,
	input  wire logic                        smp_valid,
	input  wire logic [amm_pkg::SAMP_W-1:0]  smp,
	input  wire logic                        refresh,
	input  wire logic                        sel_rms,
	output amm_pkg::amm_meter_t              meter_r
);

	logic [amm_pkg::ABS_W-1:0] abs_v;
	logic [amm_pkg::MS_W-1:0]  sq;
	logic [amm_pkg::ABS_W-1:0] peak_nxt;

	// magnitude, most negative value saturates to full scale
	always_comb begin
		if (smp[amm_pkg::SAMP_W-1]) begin
			abs_v = (smp == amm_pkg::OUT_MIN) ? amm_pkg::ABS_FS : amm_pkg::ABS_W'(~smp + 24'h000001);
		end else begin
			abs_v = smp[amm_pkg::ABS_W-1:0];
		end
		sq = abs_v[amm_pkg::ABS_W-1:amm_pkg::SQ_LSB] * abs_v[amm_pkg::ABS_W-1:amm_pkg::SQ_LSB];
		peak_nxt = (refresh || (abs_v > meter_r.peak)) ? abs_v : meter_r.peak;
	end

	// zero attack: the sample itself is the reading until refresh
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meter_r.peak <= '0;
		end else if (smp_valid) begin
			meter_r.peak <= peak_nxt; // see (RQ11)
		end else if (refresh) begin
			meter_r.peak <= '0;
		end
	end

	// slow one-pole mean square; reads average loudness, not peaks
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meter_r.ms <= '0;
		end else if (smp_valid) begin
			meter_r.ms <= meter_r.ms - (meter_r.ms >> amm_pkg::RMS_SHIFT) + (sq >> amm_pkg::RMS_SHIFT); // see (RQ20)
		end
	end

	// full scale hit is sticky until refresh; a new hit wins over the clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meter_r.over <= 1'b0;
		end else if (smp_valid && (abs_v == amm_pkg::ABS_FS)) begin
			meter_r.over <= 1'b1;
		end else if (refresh) begin
			meter_r.over <= 1'b0;
		end
	end

	// numeric reading latched on the slow refresh tick
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meter_r.readout <= '0;
		end else if (refresh) begin
			meter_r.readout <= sel_rms ? meter_r.ms : {9'h000, meter_r.peak}; // see (RQ12)
		end
	end

endmodule

// ---- rtl/amm_mixer.sv ----
// mixing and routing matrix: 30 sources to 16 outputs, per-send gains, metering
`timescale 1ns/1ps
// How it works
// (RQ1) 14 hardware inputs and 16 playback channels route to any of 16 outputs.
// (RQ2) Each of eight output pairs is an independent stereo submix.
// (RQ3) Every source has one mono send gain per output.
// (RQ4) A fader write changes only the send to the selected destination.
// (RQ5) One input may feed many outputs at once, each at its own gain.
// (RQ6) Pan splits a source over left and right sends, -3 dB each at centre.
// (RQ7) Record data is the raw input, except where loopback is enabled.
// (RQ8) Every source and output has peak and rms meters.
// (RQ9) Source meters see the signal before any send gain.
// (RQ10) Output meters see the mixed signal after all gains.
// (RQ11) Peak meter has zero attack; one full scale sample reads full scale.
// (RQ12) Numeric reading shows rms or peak, chosen by input, refreshed twice a second.
// (RQ13) A send counts as active only while its gain is above minus infinity.
// (RQ14) In trim mode a fader write shifts all active sends by the same step.
// (RQ15) Trim control gain starts at the highest of the channel's send gains.
// (RQ16) One global input switches trim mode on for every channel.
// (RQ17) Each source has its own mute and its own solo input.
// (RQ18) Each source works mono or paired with its neighbour in stereo.
// (RQ19) Outputs are saturated sums of gained sources, with a clip flag.
// (RQ20) The rms meter averages with a long time constant.
module amm_mixer #(
	parameter int REFRESH_CYCLES = amm_pkg::REFRESH_CYCLES
) (
	input  wire logic                                             mclk,
	input  wire logic                                             rstn,
	input  wire logic                                             sample_strobe,
	input  wire logic [amm_pkg::N_HW_IN-1:0][amm_pkg::SAMP_W-1:0] hw_in,
	input  wire logic [amm_pkg::N_PLAY-1:0][amm_pkg::SAMP_W-1:0]  play_in,
	input  wire logic                                             cmd_valid,
	input  wire amm_pkg::amm_cmd_t                                cmd,
	output logic                                                  cmd_ready_r,
	input  wire logic [amm_pkg::N_SRC-1:0]                        mute,
	input  wire logic [amm_pkg::N_SRC-1:0]                        solo,
	input  wire logic [amm_pkg::N_PAIR-1:0]                       stereo_pair,
	input  wire logic [amm_pkg::N_SRC-1:0][amm_pkg::PAN_W-1:0]    pan,
	input  wire logic [amm_pkg::N_SRC-1:0]                        trim_en,
	input  wire logic                                             global_trim,
	input  wire logic                                             readout_sel_rms,
	input  wire logic [amm_pkg::N_HW_IN-1:0]                      loopback,
	output logic [amm_pkg::N_OUT-1:0][amm_pkg::SAMP_W-1:0]        hw_out_r,
	output logic                                                  out_valid_r,
	output logic [amm_pkg::N_OUT-1:0]                             overload_indication_r,
	output logic [amm_pkg::N_HW_IN-1:0][amm_pkg::SAMP_W-1:0]      rec_out_r,
	output logic                                                  rec_valid_r,
	output logic [amm_pkg::N_OUT-1:0]                             route_active_r,
	output logic [amm_pkg::GAIN_W-1:0]                            trim_ctrl_gain_r,
	output amm_pkg::amm_meter_t [amm_pkg::N_SRC-1:0]              src_meter,
	output amm_pkg::amm_meter_t [amm_pkg::N_OUT-1:0]              out_meter
);

	amm_pkg::amm_state_t                                state_r;
	amm_pkg::amm_state_t                                state_nxt;
	logic [amm_pkg::SRC_W-1:0]                          idx_r;
	logic [amm_pkg::SRC_W-1:0]                          idx_nxt;
	logic                                               pend_r;
	logic                                               pend_nxt;
	logic                                               sweep_start;
	logic                                               cmd_take;
	amm_pkg::amm_cmd_t                                  cmd_r;
	logic                                               second_r;
	logic [amm_pkg::SRC_W-1:0]                          cur_src;
	logic                                               cur_ok;
	logic                                               pair_again;
	logic [amm_pkg::N_SRC-1:0][amm_pkg::SAMP_W-1:0]     src_in;
	logic [amm_pkg::N_SRC-1:0][amm_pkg::SAMP_W-1:0]     snap_r;
	logic                                               rd_vld_r;
	logic [amm_pkg::SRC_W-1:0]                          rd_idx_r;
	logic                                               fin_r;
	logic                                               pass;
	logic                                               mem_rd_en;
	logic [amm_pkg::SRC_W-1:0]                          mem_rd_addr;
	logic [amm_pkg::WORD_W-1:0]                         mem_rd_data;
	logic                                               mem_wr_en;
	logic [amm_pkg::SRC_W-1:0]                          mem_wr_addr;
	logic [amm_pkg::N_OUT-1:0]                          mem_wr_lane;
	logic [amm_pkg::WORD_W-1:0]                         mem_wr_data;
	logic [amm_pkg::WORD_W-1:0]                         new_word;
	logic [amm_pkg::GAIN_W-1:0]                         cur_max;
	logic                                               trim_on;
	logic signed [amm_pkg::GAIN_W:0]                    delta;
	logic [amm_pkg::GAIN_W-1:0]                         old_g;
	logic signed [amm_pkg::GAIN_W+1:0]                  sum_g;
	logic [amm_pkg::REFRESH_CNT_W-1:0]                  refresh_cnt_r;
	logic                                               refresh_r;

	// highest send gain in a word; zero when no send is active
	function automatic logic [amm_pkg::GAIN_W-1:0] word_max(input logic [amm_pkg::WORD_W-1:0] w);
		logic [amm_pkg::GAIN_W-1:0] m;
		m = amm_pkg::GAIN_MUTE;
		for (int l = 0; l < amm_pkg::N_OUT; l++) begin
			if (w[l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W] > m) begin
				m = w[l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W];
			end
		end
		word_max = m;
	endfunction

	// sources: hardware inputs first, playback after
	assign src_in = {play_in, hw_in};

	// the partner channel of a stereo pair is written on the second pass
	always_comb begin
		cur_src    = second_r ? (cmd_r.src ^ 5'h01) : cmd_r.src;
		cur_ok     = (cmd_r.src <= amm_pkg::LAST_SRC);
		pair_again = cur_ok && stereo_pair[cmd_r.src[4:1]] && !second_r; // see (RQ18)
	end

	// sequencer: clear the gains, then serve samples and fader writes
	always_comb begin
		state_nxt   = state_r;
		idx_nxt     = idx_r;
		sweep_start = 1'b0;
		cmd_take    = 1'b0;
		case (state_r)
			amm_pkg::AMM_S_CLEAR: begin
				idx_nxt = idx_r + 5'h01;
				if (idx_r == amm_pkg::LAST_SRC) begin
					state_nxt = amm_pkg::AMM_S_IDLE;
					idx_nxt   = amm_pkg::SRC_ZERO;
				end
			end
			amm_pkg::AMM_S_IDLE: begin
				if (cmd_valid && cmd_ready_r) begin
					cmd_take  = 1'b1;
					state_nxt = amm_pkg::AMM_S_CMD_RD;
				end else if (pend_r || sample_strobe) begin
					sweep_start = 1'b1;
					state_nxt   = amm_pkg::AMM_S_SWEEP;
					idx_nxt     = amm_pkg::SRC_ZERO;
				end
			end
			amm_pkg::AMM_S_SWEEP: begin
				idx_nxt = idx_r + 5'h01;
				if (idx_r == amm_pkg::LAST_SRC) begin
					state_nxt = amm_pkg::AMM_S_DONE;
				end
			end
			amm_pkg::AMM_S_DONE: begin
				state_nxt = amm_pkg::AMM_S_IDLE;
			end
			amm_pkg::AMM_S_CMD_RD: begin
				state_nxt = amm_pkg::AMM_S_CMD_WR;
			end
			amm_pkg::AMM_S_CMD_WR: begin
				state_nxt = pair_again ? amm_pkg::AMM_S_CMD_RD : amm_pkg::AMM_S_IDLE;
			end
			default: begin
				state_nxt = amm_pkg::AMM_S_IDLE;
			end
		endcase
		pend_nxt = (pend_r || sample_strobe) && !sweep_start;
	end

	// state, index and pending sample; a strobe during a write is kept
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r     <= amm_pkg::AMM_S_CLEAR;
			idx_r       <= amm_pkg::SRC_ZERO;
			pend_r      <= 1'b0;
			cmd_ready_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			idx_r       <= idx_nxt;
			pend_r      <= pend_nxt;
			cmd_ready_r <= (state_nxt == amm_pkg::AMM_S_IDLE) && !pend_nxt;
		end
	end

	// command capture and stereo second pass
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cmd_r    <= '0;
			second_r <= 1'b0;
		end else if (cmd_take) begin
			cmd_r    <= cmd;
			second_r <= 1'b0;
		end else if (state_r == amm_pkg::AMM_S_CMD_WR) begin
			second_r <= pair_again;
		end
	end

	// new send word: one lane normally, every active lane shifted in trim mode
	always_comb begin
		cur_max  = word_max(mem_rd_data);
		trim_on  = global_trim || trim_en[cur_src]; // see (RQ16)
		delta    = $signed({1'b0, cmd_r.gain}) - $signed({1'b0, cur_max}); // see (RQ15)
		new_word = mem_rd_data;
		old_g    = amm_pkg::GAIN_MUTE;
		sum_g    = '0;
		for (int l = 0; l < amm_pkg::N_OUT; l++) begin
			old_g = mem_rd_data[l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W];
			sum_g = $signed({2'b00, old_g}) + $signed({delta[amm_pkg::GAIN_W], delta});
			if (trim_on && (cur_max != amm_pkg::GAIN_MUTE)) begin
				if (old_g != amm_pkg::GAIN_MUTE) begin
					new_word[l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W] = sum_g[amm_pkg::GAIN_W+1] ? amm_pkg::GAIN_MUTE :
						(sum_g[amm_pkg::GAIN_W] ? amm_pkg::GAIN_UNITY : sum_g[amm_pkg::GAIN_W-1:0]); // see (RQ14)
				end
			end else if (amm_pkg::DST_W'(l) == cmd_r.dst) begin
				new_word[l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W] = cmd_r.gain; // see (RQ4)
			end
		end
	end

	// memory port steering
	always_comb begin
		mem_rd_en   = (state_r == amm_pkg::AMM_S_SWEEP) || (state_r == amm_pkg::AMM_S_CMD_RD);
		mem_rd_addr = (state_r == amm_pkg::AMM_S_SWEEP) ? idx_r : cur_src;
		mem_wr_en   = (state_r == amm_pkg::AMM_S_CLEAR) || ((state_r == amm_pkg::AMM_S_CMD_WR) && cur_ok);
		mem_wr_addr = (state_r == amm_pkg::AMM_S_CLEAR) ? idx_r : cur_src;
		mem_wr_lane = '1;
		mem_wr_data = (state_r == amm_pkg::AMM_S_CLEAR) ? '0 : new_word;
	end

	amm_gain_mem u_gain_mem (
		.mclk      (mclk),
		.rstn      (rstn),
		.rd_en     (mem_rd_en),
		.rd_addr   (mem_rd_addr),
		.rd_data_r (mem_rd_data),
		.wr_en     (mem_wr_en),
		.wr_addr   (mem_wr_addr),
		.wr_lane   (mem_wr_lane),
		.wr_data   (mem_wr_data)
	);

	// status of the last written channel: active sends and trim control gain
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			route_active_r   <= '0;
			trim_ctrl_gain_r <= amm_pkg::GAIN_MUTE;
		end else if ((state_r == amm_pkg::AMM_S_CMD_WR) && cur_ok) begin
			for (int l = 0; l < amm_pkg::N_OUT; l++) begin
				route_active_r[l] <= (new_word[l*amm_pkg::GAIN_W +: amm_pkg::GAIN_W] != amm_pkg::GAIN_MUTE); // see (RQ13)
			end
			trim_ctrl_gain_r <= word_max(new_word); // see (RQ15)
		end
	end

	// frame snapshot taken on every strobe, so input changes between strobes cannot tear a running sweep
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			snap_r <= '0;
		end else if (sample_strobe) begin
			snap_r <= src_in;
		end
	end

	// read data pipeline tag and end-of-frame pulse
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_vld_r <= 1'b0;
			rd_idx_r <= amm_pkg::SRC_ZERO;
			fin_r    <= 1'b0;
		end else begin
			rd_vld_r <= (state_r == amm_pkg::AMM_S_SWEEP);
			rd_idx_r <= idx_r;
			fin_r    <= (state_r == amm_pkg::AMM_S_DONE);
		end
	end

	// mute removes a source; any solo leaves only soloed sources in the mix
	assign pass = !mute[rd_idx_r] && (!(|solo) || solo[rd_idx_r]); // see (RQ17)

	// one multiply-accumulate lane per output
	for (genvar o = 0; o < amm_pkg::N_OUT; o++) begin : g_lane
		logic [amm_pkg::GAIN_W-1:0]      g_raw;
		logic [amm_pkg::GAIN_W-1:0]      g_att;
		logic [amm_pkg::GAIN_W-1:0]      g_eff;
		logic signed [amm_pkg::SAMP_W+amm_pkg::LIN_W:0] prod;
		logic signed [amm_pkg::ACC_W-1:0] acc_r;
		logic signed [amm_pkg::ACC_W-1:0] sh;
		logic                             ovf;

		always_comb begin
			g_raw = mem_rd_data[o*amm_pkg::GAIN_W +: amm_pkg::GAIN_W]; // see (RQ3)
			g_att = amm_pkg::amm_pan_att(pan[rd_idx_r], (o % 2) == 1); // see (RQ6)
			g_eff = (g_raw > g_att) ? (g_raw - g_att) : amm_pkg::GAIN_MUTE;
			prod  = $signed(snap_r[rd_idx_r]) * $signed({1'b0, amm_pkg::amm_gain_to_lin(g_eff)}); // see (RQ5)
			sh    = acc_r >>> amm_pkg::LIN_FRAC;
			ovf   = !((&sh[amm_pkg::ACC_W-1:amm_pkg::SAMP_W-1]) || !(|sh[amm_pkg::ACC_W-1:amm_pkg::SAMP_W-1]));
		end

		// accumulate every routed source; each pair's lanes form its own submix
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				acc_r <= '0;
			end else if (sweep_start) begin
				acc_r <= '0;
			end else if (rd_vld_r && pass) begin
				acc_r <= acc_r + amm_pkg::ACC_W'(prod); // see (RQ1) (RQ2)
			end
		end

		// saturate to the sample width; the clip flag holds for the frame
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				hw_out_r[o]              <= '0;
				overload_indication_r[o] <= 1'b0;
			end else if (fin_r) begin
				hw_out_r[o]              <= ovf ? (sh[amm_pkg::ACC_W-1] ? amm_pkg::OUT_MIN : amm_pkg::OUT_MAX) :
					sh[amm_pkg::SAMP_W-1:0]; // see (RQ19)
				overload_indication_r[o] <= ovf; // see (RQ19)
			end
		end

		// post-gain meter on the finished output
		amm_meter u_out_meter (
			.mclk      (mclk),
			.rstn      (rstn),
			.smp_valid (out_valid_r),
			.smp       (hw_out_r[o]),
			.refresh   (refresh_r),
			.sel_rms   (readout_sel_rms),
			.meter_r   (out_meter[o])
		); // see (RQ8) (RQ10)
	end

	// output frame valid, one cycle after the lanes settle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			out_valid_r <= 1'b0;
		end else begin
			out_valid_r <= fin_r;
		end
	end

	// pre-gain meters on raw source samples
	for (genvar s = 0; s < amm_pkg::N_SRC; s++) begin : g_src_meter
		amm_meter u_src_meter (
			.mclk      (mclk),
			.rstn      (rstn),
			.smp_valid (sample_strobe),
			.smp       (src_in[s]),
			.refresh   (refresh_r),
			.sel_rms   (readout_sel_rms),
			.meter_r   (src_meter[s])
		); // see (RQ8) (RQ9)
	end

	// record path bypasses the mixer; loopback returns the last mixed frame
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rec_out_r   <= '0;
			rec_valid_r <= 1'b0;
		end else begin
			rec_valid_r <= sample_strobe;
			if (sample_strobe) begin
				for (int i = 0; i < amm_pkg::N_HW_IN; i++) begin
					rec_out_r[i] <= loopback[i] ? hw_out_r[i] : hw_in[i]; // see (RQ7)
				end
			end
		end
	end

	// two hertz refresh tick for the numeric readings
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			refresh_cnt_r <= '0;
			refresh_r     <= 1'b0;
		end else if (refresh_cnt_r == amm_pkg::REFRESH_CNT_W'(REFRESH_CYCLES - 1)) begin
			refresh_cnt_r <= '0;
			refresh_r     <= 1'b1; // see (RQ12)
		end else begin
			refresh_cnt_r <= refresh_cnt_r + 24'h000001;
			refresh_r     <= 1'b0;
		end
	end

endmodule

// ---- verif/amm_mixer_monitor.sv ----
// port-level assertion checker for the mixing matrix
`timescale 1ns/1ps
module amm_mixer_monitor (
	input wire logic                       mclk,
	input wire logic                       rstn,
	input wire logic                       sample_strobe,
	input wire logic [13:0][23:0]          hw_in,
	input wire logic [13:0]                loopback,
	input wire logic                       cmd_valid,
	input wire logic                       cmd_ready_r,
	input wire logic [15:0][23:0]          hw_out_r,
	input wire logic                       out_valid_r,
	input wire logic [15:0]                overload_indication_r,
	input wire logic [13:0][23:0]          rec_out_r,
	input wire logic [15:0]                route_active_r,
	input wire logic [7:0]                 trim_ctrl_gain_r,
	input wire amm_pkg::amm_meter_t [29:0] src_meter,
	input wire amm_pkg::amm_meter_t [15:0] out_meter
);
	// single clock domain
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_rec_raw: assert property (sample_strobe && loopback == 14'h0 |=> rec_out_r == $past(hw_in))
		else $error("record data differs from input");
	a_out_window: assert property (sample_strobe |-> ##[33:39] out_valid_r)
		else $error("mixed frame late");
	a_ready_drop: assert property (cmd_valid && cmd_ready_r |=> !cmd_ready_r)
		else $error("command port stayed ready");
	a_ready_back: assert property (cmd_valid && cmd_ready_r |-> ##[3:60] cmd_ready_r)
		else $error("command port stuck busy");
	a_peak_attack: assert property (sample_strobe && hw_in[0] == amm_pkg::OUT_MAX |=>
		src_meter[0].peak == amm_pkg::ABS_FS) else $error("source peak missed full scale");
	a_over_sat: assert property (out_valid_r && overload_indication_r[0] |->
		hw_out_r[0] == amm_pkg::OUT_MAX || hw_out_r[0] == amm_pkg::OUT_MIN) else $error("clip flag without clip");
	a_trim_route: assert property ((trim_ctrl_gain_r == 8'h00) == (route_active_r == 16'h0000))
		else $error("trim gain and active sends disagree");
	a_out_meter: assert property (out_valid_r && hw_out_r[0] == amm_pkg::OUT_MAX |->
		##[0:2] out_meter[0].peak == amm_pkg::ABS_FS) else $error("output meter not post gain");
	cover property (cmd_valid && cmd_ready_r);
	cover property (out_valid_r && overload_indication_r[0]);
	cover property (sample_strobe && hw_in[0] == amm_pkg::OUT_MAX);
endmodule
bind amm_mixer amm_mixer_monitor mon (.mclk, .rstn, .sample_strobe, .hw_in, .loopback, .cmd_valid, .cmd_ready_r,
	.hw_out_r, .out_valid_r, .overload_indication_r, .rec_out_r, .route_active_r, .trim_ctrl_gain_r,
	.src_meter, .out_meter);

// ---- verif/amm_partner.sv ----
// converter and host side model: one sample frame every 64 cycles
`timescale 1ns/1ps
module amm_partner (
	input  wire logic         mclk,
	input  wire logic         run,
	input  wire logic [23:0]  level,
	output logic              sample_strobe,
	output logic [13:0][23:0] hw_in,
	output logic [15:0][23:0] play_in
);
	logic [5:0] cnt_r;
	logic       fire;
	initial {cnt_r, sample_strobe, hw_in, play_in} = '0;
	assign fire = run && cnt_r == 6'h3F;
	// data inverted outside the strobe cycle to expose late snapshots
	always @(negedge mclk) begin
		cnt_r         <= run ? cnt_r + 6'h01 : 6'h00;
		sample_strobe <= fire;
		hw_in         <= {amm_pkg::N_HW_IN{fire ? level : ~level}};
		play_in       <= {amm_pkg::N_PLAY{fire ? level : ~level}};
	end
endmodule

// ---- verif/amm_mixer_test.sv ----
// self-checking bench for the mixing matrix
`timescale 1ns/1ps
module amm_mixer_test;
	typedef struct packed {
		logic [4:0]  src;
		logic [3:0]  dst;
		logic [7:0]  gain;
		logic [4:0]  pan;
		logic [23:0] exp;
	} amm_row_t;
	logic                       mclk, rstn, run, cmd_valid, global_trim, sample_strobe;
	logic                       cmd_ready_r, out_valid_r;
	logic [23:0]                level;
	amm_pkg::amm_cmd_t          cmd;
	logic [29:0]                mute;
	logic [29:0][4:0]           pan;
	logic [13:0]                loopback;
	logic [13:0][23:0]          hw_in, rec_out_r;
	logic [15:0][23:0]          play_in, hw_out_r;
	logic [15:0]                overload_indication_r, route_active_r;
	logic [7:0]                 trim_ctrl_gain_r;
	amm_pkg::amm_meter_t [29:0] src_meter;
	amm_pkg::amm_meter_t [15:0] out_meter;
	int                         fails = 0, total_checks = 0, cycles = 0;
	// unity, -6 dB, centre pan both sides, silent send
	amm_row_t rows[5] = '{'{5'h00, 4'h0, 8'hFF, 5'h00, 24'h0FFFE0}, '{5'h0D, 4'h2, 8'hF3, 5'h00, 24'h07FFE0},
		'{5'h1D, 4'h4, 8'hFF, 5'h0C, 24'h0B53C0}, '{5'h1D, 4'h5, 8'hFF, 5'h0C, 24'h0B53C0},
		'{5'h0E, 4'h6, 8'h00, 5'h00, 24'h000000}};
	amm_partner src_side (.mclk, .run, .level, .sample_strobe, .hw_in, .play_in);
	amm_mixer #(.REFRESH_CYCLES(64)) dut (.mclk, .rstn, .sample_strobe, .hw_in, .play_in, .cmd_valid, .cmd,
		.cmd_ready_r, .mute, .solo('0), .stereo_pair('0), .pan, .trim_en('0), .global_trim, .readout_sel_rms(1'b0),
		.loopback, .hw_out_r, .out_valid_r, .overload_indication_r, .rec_out_r, .rec_valid_r(),
		.route_active_r, .trim_ctrl_gain_r, .src_meter, .out_meter);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// hold the request until taken
	task automatic wr(input logic [4:0] s, input logic [3:0] d, input logic [7:0] g);
		@(negedge mclk);
		cmd       = '{s, d, g};
		cmd_valid = 1'b1;
		do @(posedge mclk); while (cmd_ready_r !== 1'b1);
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask
	// second frame is wholly after the change
	task automatic frame();
		repeat (2) @(posedge out_valid_r);
		@(negedge mclk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// hang guard, about fifteen times the run's length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		{rstn, run, cmd_valid, global_trim, mute, pan, cmd, loopback} = '0;
		level = 24'h100000;
		repeat (20) @(negedge mclk);
		check(hw_out_r[0], 32'h0);
		rstn = 1'b1;
		run  = 1'b1;
		foreach (rows[i]) begin
			pan = {30{rows[i].pan}};
			wr(rows[i].src, rows[i].dst, rows[i].gain);
			frame();
			check(hw_out_r[rows[i].dst], rows[i].exp);
			check(route_active_r[rows[i].dst], rows[i].gain != 8'h00);
		end
		wr(5'h00, 4'h8, 8'hFF);
		frame();
		check(hw_out_r[8], 32'h0FFFE0);
		check(hw_out_r[0], 32'h0FFFE0);
		check(rec_out_r[3], 32'h100000);
		level = 24'h7FFFFF;
		wr(5'h01, 4'h0, 8'hFF);
		frame();
		check(hw_out_r[0], 32'h7FFFFF);
		check(overload_indication_r[0], 32'h1);
		mute[0] = 1'b1;
		frame();
		check(hw_out_r[8], 32'h0);
		mute[0]     = 1'b0;
		global_trim = 1'b1;
		wr(5'h00, 4'h3, 8'hF3);
		frame();
		check(trim_ctrl_gain_r, 32'hF3);
		check(route_active_r, 32'h0101);
		check(hw_out_r[8], 32'h3FFEFF);
		loopback[8] = 1'b1;
		frame();
		check(rec_out_r[8], 32'h3FFEFF);
		conclude();
	end
endmodule
